// ### design/dialer_pkg.sv
// Constants, codes and states of the pulse/tone dialer control block
//------------------------------------------------------------------
//------------------------------------------------------------------
package dialer_pkg;
	localparam int CLK_PERIOD_NS = 50;
	localparam int MS_NS = 1000000;
	localparam int MS_TICK_DEFAULT = MS_NS / CLK_PERIOD_NS;
	localparam int MS_PER_S = 1000;
	localparam logic [4:0] MEM_DEPTH = 5'(28);
	// Rates per second or in Hz, times in milliseconds
	localparam int PULSE_RATE_PPS = 10;
	localparam int TONE_RATE_PER_S = 5;
	localparam int SCAN_HZ = 250;
	localparam int PACIFIER_HZ = 500;
	localparam logic [11:0] HOOK_FLASH_TIME = 12'(600);
	localparam logic [11:0] BREAK_MS = 12'(60);
	localparam logic [11:0] MAKE_MS = 12'(MS_PER_S / PULSE_RATE_PPS - 60);
	localparam logic [11:0] PREDIGIT_PAUSE_TIME = 12'(140);
	localparam logic [11:0] INTERDIGIT_PAUSE_TIME = 12'(940);
	localparam logic [11:0] MUTE_OVERLAP_MS = 12'(4);
	localparam logic [11:0] IDP_REST_MS = INTERDIGIT_PAUSE_TIME - MUTE_OVERLAP_MS;
	localparam logic [11:0] PRESIGNAL_DELAY_TIME = 12'(100);
	localparam logic [11:0] INTERSIGNAL_DELAY_TIME = 12'(100);
	localparam logic [11:0] TONE_MS = 12'(MS_PER_S / TONE_RATE_PER_S - 100);
	localparam logic [11:0] PAUSE_MS = 12'(3000);
	localparam logic [3:0] SCAN_MS = 4'(MS_PER_S / SCAN_HZ);
	localparam logic [3:0] DEBOUNCE_SCANS = 4'(32 / (MS_PER_S / SCAN_HZ));
	localparam logic [1:0] PAC_HALF_MS = 2'(MS_PER_S / PACIFIER_HZ / 2);
	localparam logic [5:0] PAC_MS = 6'(30);
	// Entry codes
	localparam logic [3:0] CODE_ZERO = 4'h0;
	localparam logic [3:0] CODE_NINE = 4'h9;
	localparam logic [3:0] CODE_STAR = 4'ha;
	localparam logic [3:0] CODE_POUND = 4'hb;
	localparam logic [3:0] CODE_MODE = 4'hc;
	localparam logic [3:0] CODE_PAUSE = 4'hd;
	localparam logic [3:0] CODE_FLASH = 4'he;
	localparam logic [3:0] CODE_REDIAL = 4'hf;
	localparam logic [3:0] ZERO_BREAKS = 4'ha;
	// Register map
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_KEY = 8'h04;
	localparam logic [7:0] ADDR_STAT = 8'h08;
	localparam logic CTRL_EN_RESET = 1'b1;
	localparam int CTRL_EN_BIT = 0;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic HRESP_OKAY = 1'b0;
	typedef enum logic [3:0] {S_IDLE, S_FETCH, S_PRE, S_BREAK, S_MAKE, S_OVL, S_GAP,
		S_TONE, S_HOLD} sig_state_t;
endpackage

// ### design/dialer_ctrl.sv
// Dialer control: key entry, redial memory, pulse/tone sequencing, AHB-Lite registers
`timescale 1ns/10ps
`default_nettype none
module dialer_ctrl
	import dialer_pkg::*;
#(
	parameter int MS_TICK_CYCLES = MS_TICK_DEFAULT
)
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic hook_switch_input,
	input wire logic mode_select,
	input wire logic bcd_select,
	input wire logic [3:0] key_row_n,
	input wire logic [3:0] key_col_n,
	output logic line_break_oe,
	output logic line_mute_output_oe,
	output logic pacifier_out,
	output logic tone_on,
	output logic [3:0] tone_code
);

	// One-hot low decode: {valid, index}
	function automatic logic [2:0] onehot_low(input logic [3:0] v);
		logic [2:0] r;
		r = 3'h0;
		unique case (v)
			4'he: r = 3'h4;
			4'hd: r = 3'h5;
			4'hb: r = 3'h6;
			4'h7: r = 3'h7;
			default: r = 3'h0;
		endcase
		return r;
	endfunction

	// Keypad position to entry code
	function automatic logic [3:0] key_code(input logic [1:0] row, input logic [1:0] col);
		logic [3:0] c;
		c = CODE_ZERO;
		if (col == 2'h3)
			c = (row == 2'h0) ? CODE_FLASH : (row == 2'h1) ? CODE_MODE :
				(row == 2'h2) ? CODE_PAUSE : CODE_REDIAL;
		else if (row == 2'h3)
			c = (col == 2'h0) ? CODE_STAR : (col == 2'h1) ? CODE_ZERO : CODE_POUND;
		else
			c = 4'({row, 2'h0} - {2'h0, row} + {2'h0, col} + 4'h1);
		return c;
	endfunction

	//------------------------------------------------------------------
	// Declarations
	//------------------------------------------------------------------
	logic [14:0] tick_cnt_q;
	logic ms_tick_q;
	logic [3:0] scan_cnt_q;
	logic scan_tick;
	logic init_pend_q, hook_q, mode_pin_q, mode_q, bcd_q, ctrl_en_q;
	logic init_ev;
	logic [3:0] mem [0:27];
	logic [4:0] wr_q, rd_q, len_q;
	logic fresh_q, redial_q;
	logic [3:0] cand_q, db_cnt_q, kp_code_q, strb_code_q;
	logic key_down_q, held_q, kp_acc_q, strb_q;
	logic [2:0] row_dec, col_dec;
	logic strb_acc, bus_key_v;
	logic ent_v;
	logic [3:0] ent_code;
	logic store_v, start_redial, live_toggle, seq_toggle;
	sig_state_t st_q;
	logic [11:0] tmr_q;
	logic [3:0] pcnt_q, fetch_code;
	logic sig_tone_q, sig_go;
	logic [5:0] pac_tmr_q;
	logic [1:0] pac_ph_q;
	logic ap_wr_q;
	logic [7:0] ap_addr_q;

	//------------------------------------------------------------------
	// Millisecond and scan ticks
	//------------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			tick_cnt_q <= 15'h0;
			ms_tick_q <= 1'b0;
			scan_cnt_q <= 4'h0;
		end
		else
		begin
			ms_tick_q <= (tick_cnt_q == 15'(MS_TICK_CYCLES - 1));
			tick_cnt_q <= (tick_cnt_q == 15'(MS_TICK_CYCLES - 1)) ? 15'h0 : tick_cnt_q + 15'h1;
			if (ms_tick_q)
				scan_cnt_q <= (scan_cnt_q == SCAN_MS - 4'h1) ? 4'h0 : scan_cnt_q + 4'h1;
		end
	end
	assign scan_tick = ms_tick_q && (scan_cnt_q == SCAN_MS - 4'h1);

	//------------------------------------------------------------------
	// Hook, mode pin and input mode
	//------------------------------------------------------------------
	// init on any hook edge
	assign init_ev = init_pend_q || (hook_switch_input != hook_q);
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			init_pend_q <= 1'b1;
			hook_q <= 1'b1;
			mode_pin_q <= 1'b0;
			bcd_q <= 1'b0;
		end
		else
		begin
			init_pend_q <= 1'b0;
			hook_q <= hook_switch_input;
			mode_pin_q <= mode_select;
			if (init_pend_q || hook_switch_input)
				bcd_q <= bcd_select;
		end
	end

	assign live_toggle = store_v && (ent_code == CODE_MODE);
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			mode_q <= 1'b0;
		else if (init_ev)
			mode_q <= mode_select;
		else
			mode_q <= mode_q ^ (mode_select != mode_pin_q) ^ live_toggle ^ seq_toggle;
	end

	//------------------------------------------------------------------
	// Keypad debounce and binary strobe
	//------------------------------------------------------------------
	assign row_dec = onehot_low(key_row_n);
	assign col_dec = onehot_low(key_col_n);
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			cand_q <= 4'h0;
			db_cnt_q <= 4'h0;
			key_down_q <= 1'b0;
			held_q <= 1'b0;
			kp_acc_q <= 1'b0;
			kp_code_q <= 4'h0;
		end
		else
		begin
			kp_acc_q <= 1'b0;
			if (scan_tick)
			begin
				if (!(row_dec[2] && col_dec[2]) || bcd_q)
				begin
					key_down_q <= 1'b0;
					held_q <= 1'b0;
					db_cnt_q <= 4'h0;
				end
				else
				begin
					key_down_q <= 1'b1;
					if (!held_q)
					begin
						if (cand_q == key_code(row_dec[1:0], col_dec[1:0]))
						begin
							db_cnt_q <= db_cnt_q + 4'h1;
							if (db_cnt_q == DEBOUNCE_SCANS - 4'h1)
							begin
								kp_acc_q <= 1'b1;
								kp_code_q <= cand_q;
								held_q <= 1'b1;
							end
						end
						else
						begin
							cand_q <= key_code(row_dec[1:0], col_dec[1:0]);
							db_cnt_q <= 4'h0;
						end
					end
				end
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			strb_q <= 1'b0;
			strb_code_q <= 4'h0;
		end
		else
		begin
			strb_q <= key_col_n[0];
			if (key_col_n[0])
				strb_code_q <= key_row_n;
		end
	end
	assign strb_acc = bcd_q && strb_q && !key_col_n[0];

	//------------------------------------------------------------------
	// Entry handling and redial memory
	//------------------------------------------------------------------
	always_comb
	begin
		ent_v = 1'b1;
		ent_code = kp_code_q;
		if (kp_acc_q)
			ent_code = kp_code_q;
		else if (strb_acc)
			ent_code = strb_code_q;
		else if (bus_key_v)
			ent_code = hwdata[3:0];
		else
			ent_v = 1'b0;
	end
	assign start_redial = ent_v && !redial_q && ent_code == CODE_REDIAL && fresh_q &&
		len_q != 5'h0;
	assign store_v = ent_v && !redial_q && ent_code != CODE_REDIAL && wr_q < MEM_DEPTH;

	always_ff @(posedge hclk)
	begin
		if (store_v)
			mem[wr_q] <= ent_code;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_q <= 5'h0;
			len_q <= 5'h0;
			fresh_q <= 1'b1;
			redial_q <= 1'b0;
		end
		else if (init_ev)
		begin
			wr_q <= 5'h0;
			fresh_q <= 1'b1;
			redial_q <= 1'b0;
		end
		else
		begin
			if (redial_q && st_q == S_IDLE && rd_q == wr_q)
				redial_q <= 1'b0;
			if (start_redial)
			begin
				redial_q <= 1'b1;
				wr_q <= len_q;
				fresh_q <= 1'b0;
			end
			else if (store_v)
			begin
				wr_q <= wr_q + 5'h1;
				len_q <= wr_q + 5'h1;
				fresh_q <= 1'b0;
			end
		end
	end

	//------------------------------------------------------------------
	// Signaling sequencer
	//------------------------------------------------------------------
	assign sig_go = !hook_switch_input && ctrl_en_q;
	assign fetch_code = mem[rd_q];
	// stored mode entry toggles on replay
	assign seq_toggle = st_q == S_FETCH && rd_q != wr_q && redial_q && fetch_code == CODE_MODE;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			st_q <= S_IDLE;
			tmr_q <= 12'h0;
			pcnt_q <= 4'h0;
			rd_q <= 5'h0;
			sig_tone_q <= 1'b0;
			line_break_oe <= 1'b0;
			line_mute_output_oe <= 1'b0;
			tone_on <= 1'b0;
			tone_code <= 4'h0;
		end
		else if (init_ev)
		begin
			st_q <= S_IDLE;
			rd_q <= 5'h0;
			line_break_oe <= 1'b0;
			line_mute_output_oe <= 1'b0;
			tone_on <= 1'b0;
		end
		else
		begin
			if (ms_tick_q && tmr_q != 12'h0)
				tmr_q <= tmr_q - 12'h1;
			unique case (st_q)
				S_IDLE:
				begin
					line_mute_output_oe <= 1'b0;
					if (sig_go && rd_q != wr_q)
						st_q <= S_FETCH;
				end
				S_FETCH:
				begin
					if (rd_q == wr_q || !sig_go)
					begin
						st_q <= S_IDLE;
						line_mute_output_oe <= 1'b0;
					end
					else
					begin
						rd_q <= rd_q + 5'h1;
						sig_tone_q <= mode_q;
						tone_code <= fetch_code;
						if (fetch_code == CODE_PAUSE)
						begin
							st_q <= S_HOLD;
							tmr_q <= PAUSE_MS;
							line_mute_output_oe <= 1'b0;
						end
						else if (fetch_code == CODE_FLASH)
						begin
							st_q <= S_HOLD;
							tmr_q <= HOOK_FLASH_TIME;
							line_break_oe <= 1'b1;
							line_mute_output_oe <= 1'b1;
						end
						else if (fetch_code <= CODE_NINE && !mode_q)
						begin
							st_q <= S_PRE;
							tmr_q <= PREDIGIT_PAUSE_TIME;
							pcnt_q <= (fetch_code == CODE_ZERO) ? ZERO_BREAKS : fetch_code;
							line_mute_output_oe <= 1'b1;
						end
						else if (fetch_code <= CODE_POUND && mode_q)
						begin
							// presignal delay only when mute is off
							st_q <= line_mute_output_oe ? S_TONE : S_PRE;
							tmr_q <= line_mute_output_oe ? TONE_MS : PRESIGNAL_DELAY_TIME;
							tone_on <= line_mute_output_oe;
							line_mute_output_oe <= 1'b1;
						end
					end
				end
				S_PRE:
					if (tmr_q == 12'h0)
					begin
						st_q <= sig_tone_q ? S_TONE : S_BREAK;
						tmr_q <= sig_tone_q ? TONE_MS : BREAK_MS;
						tone_on <= sig_tone_q;
						line_break_oe <= !sig_tone_q;
					end
				S_BREAK:
					if (tmr_q == 12'h0)
					begin
						line_break_oe <= 1'b0;
						pcnt_q <= pcnt_q - 4'h1;
						st_q <= (pcnt_q == 4'h1) ? S_OVL : S_MAKE;
						tmr_q <= (pcnt_q == 4'h1) ? MUTE_OVERLAP_MS : MAKE_MS;
					end
				S_MAKE:
					if (tmr_q == 12'h0)
					begin
						st_q <= S_BREAK;
						tmr_q <= BREAK_MS;
						line_break_oe <= 1'b1;
					end
				S_OVL:
					// mute outlasts train by 4 ms
					if (tmr_q == 12'h0)
					begin
						line_mute_output_oe <= 1'b0;
						st_q <= S_GAP;
						tmr_q <= IDP_REST_MS;
					end
				S_TONE:
					if (tmr_q == 12'h0)
					begin
						tone_on <= 1'b0;
						st_q <= S_GAP;
						tmr_q <= INTERSIGNAL_DELAY_TIME;
					end
				S_GAP:
					if (tmr_q == 12'h0 && !key_down_q)
						st_q <= S_FETCH;
				S_HOLD:
					if (tmr_q == 12'h0)
					begin
						line_break_oe <= 1'b0;
						line_mute_output_oe <= 1'b0;
						st_q <= S_FETCH;
					end
			endcase
		end
	end

	//------------------------------------------------------------------
	// Pacifier tone
	//------------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			pac_tmr_q <= 6'h0;
			pac_ph_q <= 2'h0;
			pacifier_out <= 1'b0;
		end
		// 30 ms of 500 Hz per entry outside redial, in pulse mode or on the redial code
		else if (ent_v && !redial_q && (!mode_q || ent_code == CODE_REDIAL))
		begin
			pac_tmr_q <= PAC_MS;
			pac_ph_q <= 2'h0;
			pacifier_out <= 1'b1;
		end
		else if (pac_tmr_q == 6'h0)
			pacifier_out <= 1'b0;
		else if (ms_tick_q)
		begin
			pac_tmr_q <= pac_tmr_q - 6'h1;
			pac_ph_q <= (pac_ph_q == PAC_HALF_MS - 2'h1) ? 2'h0 : pac_ph_q + 2'h1;
			if (pac_ph_q == PAC_HALF_MS - 2'h1)
				pacifier_out <= !pacifier_out;
		end
	end

	//------------------------------------------------------------------
	// AHB-Lite slave
	//------------------------------------------------------------------
	assign bus_key_v = ap_wr_q && ap_addr_q == ADDR_KEY;
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ap_wr_q <= 1'b0;
			ap_addr_q <= 8'h0;
			hrdata <= 32'h0;
			hreadyout <= 1'b1;
			hresp <= HRESP_OKAY;
			ctrl_en_q <= CTRL_EN_RESET;
		end
		else
		begin
			hreadyout <= 1'b1;
			hresp <= HRESP_OKAY;
			if (ap_wr_q && ap_addr_q == ADDR_CTRL)
				ctrl_en_q <= hwdata[CTRL_EN_BIT];
			ap_wr_q <= 1'b0;
			if (hsel && hready && htrans == HTRANS_NONSEQ)
			begin
				ap_wr_q <= hwrite;
				ap_addr_q <= haddr[7:0];
				hrdata <= 32'h0;
				if (!hwrite && haddr[7:0] == ADDR_CTRL)
					hrdata <= {31'h0, ctrl_en_q};
				else if (!hwrite && haddr[7:0] == ADDR_STAT)
					hrdata <= {11'h0, rd_q, 3'h0, wr_q, 2'h0, st_q != S_IDLE, bcd_q,
						hook_switch_input, redial_q, key_down_q, mode_q};
			end
		end
	end

	//------------------------------------------------------------------
	// Assertions
	//------------------------------------------------------------------
	a_mem_bound:
	assert property (@(posedge hclk) disable iff (!hresetn) wr_q <= MEM_DEPTH)
		else $error("redial memory pointer beyond depth");
	a_redial_nostore:
	assert property (@(posedge hclk) disable iff (!hresetn)
		(redial_q && ent_v && !init_ev) |=> $stable(wr_q))
		else $error("entry stored during redial");
	a_mode_key:
	assert property (@(posedge hclk) disable iff (!hresetn)
		(live_toggle && !init_ev && mode_select == mode_pin_q && !seq_toggle)
		|=> mode_q != $past(mode_q))
		else $error("mode key did not invert mode");
	a_hook_default:
	assert property (@(posedge hclk) disable iff (!hresetn)
		(hook_switch_input != hook_q) |=> (st_q == S_IDLE && mode_q == $past(mode_select)))
		else $error("hook edge did not reinitialise");
	a_break_load:
	assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(line_break_oe) && st_q == S_BREAK |-> tmr_q == BREAK_MS)
		else $error("break not loaded with 60 ms");
	a_break_muted:
	assert property (@(posedge hclk) disable iff (!hresetn)
		line_break_oe |-> line_mute_output_oe)
		else $error("line broken without mute");
	a_tone_muted:
	assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(tone_on) |-> $past(line_mute_output_oe))
		else $error("tone started before mute");
	a_gap_stall:
	assert property (@(posedge hclk) disable iff (!hresetn)
		(st_q == S_GAP && key_down_q && !init_ev) |=> st_q == S_GAP)
		else $error("gap left while key held");
	a_pacifier_start:
	assert property (@(posedge hclk) disable iff (!hresetn)
		(kp_acc_q && !redial_q && !mode_q) |=> (pac_tmr_q == PAC_MS && pacifier_out))
		else $error("pacifier not started");
	a_bus_okay:
	assert property (@(posedge hclk) disable iff (!hresetn) hreadyout && hresp == HRESP_OKAY)
		else $error("bus answer not ready okay");

endmodule
`default_nettype wire

// ### test/keypad_model.sv
// Keypad model for the dialer control bench
`timescale 1ns/10ps
`default_nettype none
module keypad_model
(
	input wire logic press,
	input wire logic [3:0] code,
	input wire logic bcd,
	output logic [3:0] key_row_n,
	output logic [3:0] key_col_n
);
	//------------------------------------------------------------------
	// Contact map, two bits per code, code 0 at the bottom
	//------------------------------------------------------------------
	localparam logic [31:0] ROW_OF = 32'hc9fa_9503;
	localparam logic [31:0] COL_OF = 32'hff89_2491;
	logic [1:0] row;
	logic [1:0] col;
	assign row = ROW_OF[2 * code +: 2];
	assign col = COL_OF[2 * code +: 2];
	always_comb
	begin
		key_row_n = 4'hf;
		key_col_n = 4'hf;
		if (bcd)
		begin
			// host code on rows, strobe on column 0
			key_row_n = code;
			key_col_n[0] = press;
		end
		else if (press)
		begin
			key_row_n[row] = 1'b0;
			key_col_n[col] = 1'b0;
		end
	end
endmodule
`default_nettype wire

// ### test/pulse_tone_dialer_control_bench.sv
// Self-checking bench for the dialer control block
`timescale 1ns/10ps
`default_nettype none
module pulse_tone_dialer_control_bench import dialer_pkg::*;;
	localparam int MS = 20;
	logic hclk, hresetn, hsel, hwrite, hook, mode_sel, press;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans;
	logic [3:0] code, row_n, col_n, tone_code;
	logic brk, mute, pac, tone_on;
	logic hresp, bcd_sel;
	wire logic hready;
	int n_mismatch, checks;
	//------------------------------------------------------------------
	// Design and keypad
	//------------------------------------------------------------------
	dialer_ctrl #(.MS_TICK_CYCLES(MS)) DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
		.hook_switch_input(hook), .mode_select(mode_sel), .bcd_select(bcd_sel),
		.key_row_n(row_n), .key_col_n(col_n), .line_break_oe(brk),
		.line_mute_output_oe(mute), .pacifier_out(pac), .tone_on(tone_on),
		.tone_code(tone_code));
	keypad_model keys (.press(press), .code(code), .bcd(bcd_sel), .key_row_n(row_n),
		.key_col_n(col_n));
	always #25 hclk = ~hclk;
	//------------------------------------------------------------------
	// Helpers
	//------------------------------------------------------------------
	task final_report;
		$display("mismatches %0d comparisons %0d", n_mismatch, checks);
		if (n_mismatch == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task rng(input int got, input int lo, input int hi);
		checks++;
		if (got < lo || got > hi)
		begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h to %h", $time, got, lo, hi);
		end
	endtask
	function logic pick(input int s);
		case (s)
			0: return brk;
			1: return mute;
			2: return tone_on;
			default: return pac;
		endcase
	endfunction
	task wait_sig(input int s, input logic v, input int lim, input bit must, output int n);
		n = 0;
		while (pick(s) !== v && n < lim)
		begin
			@(negedge hclk);
			n++;
		end
		if (must && n >= lim)
		begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, pick(s), v);
			final_report;
		end
	endtask
	task bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] r);
		int k;
		k = 0;
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= HTRANS_NONSEQ;
		haddr <= {24'h00_0000, a};
		hwrite <= w;
		do
		begin
			@(posedge hclk);
			k++;
		end
		while (hready !== 1'b1 && k < 50);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do
		begin
			@(posedge hclk);
			k++;
		end
		while (hready !== 1'b1 && k < 100);
		r = hrdata;
		chk({31'h0, hresp}, {31'h0, HRESP_OKAY});
		if (k >= 100)
		begin
			n_mismatch++;
			final_report;
		end
	endtask
	task settle(input int ms);
		repeat (ms * MS) @(posedge hclk);
	endtask
	task set_key(input logic p, input logic [3:0] c);
		@(posedge hclk);
		press <= p;
		code <= c;
	endtask
	task pulse_digit(input int n_exp, output int g);
		int w, m, n;
		n = 0;
		wait_sig(1, 1'b1, 20000, 1'b1, g);
		wait_sig(0, 1'b1, 3000, 1'b1, w);
		rng(w, 2700, 2800);
		do
		begin
			wait_sig(0, 1'b0, 1300, 1'b1, w);
			rng(w, 1180, 1200);
			n++;
			wait_sig(1, 1'b0, 120, 1'b0, m);
			if (m >= 120)
			begin
				wait_sig(0, 1'b1, 800, 1'b1, w);
				rng(w, 660, 680);
			end
		end
		while (m >= 120 && n < 12);
		rng(m, 60, 80);
		chk(n, n_exp);
	endtask
	//------------------------------------------------------------------
	// Scenarios
	//------------------------------------------------------------------
	task regs_check;
		logic [31:0] r;
		bus(1'b0, ADDR_CTRL, 32'h0, r);
		chk({31'h0, r[0]}, {31'h0, CTRL_EN_RESET});
		bus(1'b1, ADDR_CTRL, 32'h0, r);
		bus(1'b0, ADDR_CTRL, 32'h0, r);
		chk(r, 32'h0);
		bus(1'b1, ADDR_CTRL, 32'h1, r);
		bus(1'b0, ADDR_CTRL, 32'h0, r);
		chk(r, 32'h1);
		bus(1'b0, 8'h10, 32'h0, r);
		chk(r, 32'h0);
		bus(1'b0, ADDR_STAT, 32'h0, r);
		chk({30'h0, r[3], r[0]}, 32'h3);
		bus(1'b1, ADDR_KEY, {28'h0, CODE_MODE}, r);
		bus(1'b0, ADDR_STAT, 32'h0, r);
		chk({26'h0, r[12:8], r[0]}, 32'h2);
		mode_sel <= 1'b0;
		bus(1'b0, ADDR_STAT, 32'h0, r);
		chk({26'h0, r[12:8], r[0]}, 32'h3);
		hook <= 1'b0;
		bus(1'b0, ADDR_STAT, 32'h0, r);
		chk({26'h0, r[12:8], r[0]}, 32'h0);
	endtask
	task pulse_check;
		logic [31:0] r;
		int w, g;
		set_key(1'b1, 4'h7);
		settle(20);
		set_key(1'b0, 4'h7);
		wait_sig(1, 1'b1, 40 * MS, 1'b0, w);
		chk(w, 40 * MS);
		set_key(1'b1, 4'h2);
		wait_sig(1, 1'b1, 40 * MS, 1'b1, w);
		rng(w, 32 * MS, 38 * MS);
		set_key(1'b0, 4'h2);
		wait_sig(3, 1'b1, 40, 1'b1, w);
		wait_sig(3, 1'b0, 40, 1'b1, w);
		bus(1'b1, ADDR_KEY, {28'h0, CODE_ZERO}, r);
		pulse_digit(2, g);
		pulse_digit(10, g);
		rng(g, 18710, 18730);
	endtask
	task redial_check;
		logic [31:0] r;
		int w;
		@(posedge hclk);
		hook <= 1'b1;
		settle(4);
		mode_sel <= 1'b1;
		settle(4);
		hook <= 1'b0;
		settle(8);
		set_key(1'b1, CODE_REDIAL);
		wait_sig(1, 1'b1, 40 * MS, 1'b1, w);
		set_key(1'b0, CODE_REDIAL);
		wait_sig(2, 1'b1, 2100, 1'b1, w);
		rng(w, 1970, 2000);
		chk({28'h0, tone_code}, 32'h2);
		wait_sig(2, 1'b0, 2100, 1'b1, w);
		rng(w, 1980, 2000);
		wait_sig(2, 1'b1, 2100, 1'b1, w);
		rng(w, 1990, 2010);
		chk({27'h0, mute, tone_code}, 32'h10);
		wait_sig(2, 1'b0, 2100, 1'b1, w);
		wait_sig(1, 1'b0, 2200, 1'b1, w);
		rng(w, 1980, 2020);
		bus(1'b1, ADDR_KEY, {28'h0, CODE_FLASH}, r);
		wait_sig(0, 1'b1, 200, 1'b1, w);
		wait_sig(0, 1'b0, 12100, 1'b1, w);
		rng(w, 11980, 12000);
		bus(1'b1, ADDR_KEY, {28'h0, CODE_FLASH}, r);
		wait_sig(0, 1'b1, 200, 1'b1, w);
		@(posedge hclk);
		hook <= 1'b1;
		wait_sig(0, 1'b0, 5, 1'b0, w);
		chk({31'h0, brk}, 32'h0);
	endtask
	task binary_check;
		logic [31:0] r;
		@(posedge hclk);
		bcd_sel <= 1'b1;
		settle(4);
		hook <= 1'b0;
		settle(4);
		// strobe 1 ms wide, 10 ms apart
		set_key(1'b1, CODE_REDIAL);
		settle(1);
		set_key(1'b0, CODE_REDIAL);
		settle(10);
		set_key(1'b1, 4'h5);
		settle(1);
		set_key(1'b0, 4'h5);
		settle(1);
		bcd_sel <= 1'b0;
		bus(1'b0, ADDR_STAT, 32'h0, r);
		chk({25'h0, r[12:8], r[4], r[2]}, 32'h13);
	endtask
	initial
	begin
		hclk = 1'b0;
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		hook = 1'b1;
		mode_sel = 1'b1;
		press = 1'b0;
		code = 4'h0;
		bcd_sel = 1'b0;
		n_mismatch = 0;
		checks = 0;
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (2) @(posedge hclk);
		regs_check;
		pulse_check;
		redial_check;
		binary_check;
		final_report;
	end
endmodule
`default_nettype wire
